// File: hdl/rds_sync_regs.vh
// register indices, field positions, reset values and timing for the group/block sync unit
// assumes: byte address of a register is four times its index, data in bits 7:0
`ifndef RDS_SYNC_REGS_VH
`define RDS_SYNC_REGS_VH

// ***************************************
// register indices
// ***************************************
`define IDX_SHIFT_CHECKWORD_LOW 8'h60
`define IDX_SHIFT_CHECKWORD_HIGH 8'h61
`define IDX_SHIFT_MESSAGE_LOW 8'h62
`define IDX_SHIFT_MESSAGE_HIGH 8'h63
`define IDX_SYNDROME_LOW_BLOCKCODE 8'h64
`define IDX_SYNDROME_HIGH 8'h65
`define IDX_BIT_BLOCK_COUNTERS 8'h66
`define IDX_INTERRUPT_CONTROL 8'h67
`define IDX_SHADOW_DATA_LOW_FLAGS 8'h68
`define IDX_SHADOW_DATA_BYTE1 8'h69
`define IDX_SHADOW_DATA_BYTE2 8'h6a
`define IDX_SHADOW_DATA_BYTE3 8'h6b
`define IDX_QUALITY_BYTE0 8'h6c
`define IDX_QUALITY_BYTE1 8'h6d
`define IDX_QUALITY_BYTE2 8'h6e
`define IDX_QUALITY_BYTE3 8'h6f
`define IDX_FIRST 8'h60
`define IDX_LAST 8'h6f

// ***************************************
// field positions
// ***************************************
`define BIT_PAGING 4
`define BIT_CAL 7
`define BIT_ECM 5
`define BIT_VSF 4
`define BIT_VSE 3
`define BIT_CNF 2

// ***************************************
// reset values and constants
// ***************************************
`define RST_BIT_CNT 5'h1f
`define RST_BLK_CNT 2'h3
`define RST_ORDER 1'b1
`define SYN_POLY 10'h1b9
`define SYN_A 10'h3d8
`define SYN_B 10'h3d4
`define SYN_C 10'h25c
`define SYN_CP 10'h3cc
`define SYN_D 10'h258
`define SYN_E 10'h000
`define CODE_A 3'h2
`define CODE_B 3'h1
`define CODE_C 3'h4
`define CODE_CP 3'h0
`define CODE_D 3'h3
`define CODE_E 3'h5
`define CODE_WRONG 3'h7
`define SEQ_LAST_ROT 5'h19
`define SEQ_END 5'h1b
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/rds_group_block_sync.v
// group and block synchronisation unit with its sixteen registers on AXI4-Lite
// assumes: demodulator pins are asynchronous to sys_clk; bit clock far slower than sys_clk
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rds_sync_regs.vh"

module rds_group_block_sync (
    input wire sys_clk,
    input wire arst_n,
    input wire rds_bit_clock,
    input wire rds_serial_bit,
    input wire rds_quality,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire sync_unit_irq_line
);

    // ***************************************
    // functions
    // ***************************************
    function reg_hit;
        input [11:0] addr;
        begin
            reg_hit = ({2'b00, addr[11:6]} == (`IDX_FIRST >> 4));
        end
    endfunction

    // one rotate clock: rotate shift register, feed msb into the divider
    function [35:0] rot_step;
        input [25:0] sr;
        input [9:0] syn;
        reg fb;
        begin
            fb = syn[9] ^ sr[25];
            rot_step = {sr[24:0], sr[25], {syn[8:0], 1'b0} ^ (fb ? `SYN_POLY : 10'h000)};
        end
    endfunction

    // returns {valid, block code}
    function [3:0] syn_decode;
        input [9:0] syn;
        input paging;
        begin
            case (syn)
                `SYN_A: syn_decode = {1'b1, `CODE_A};
                `SYN_B: syn_decode = {1'b1, `CODE_B};
                `SYN_C: syn_decode = {1'b1, `CODE_C};
                `SYN_CP: syn_decode = {1'b1, `CODE_CP};
                `SYN_D: syn_decode = {1'b1, `CODE_D};
                `SYN_E: syn_decode = paging ? {1'b1, `CODE_E} : {1'b0, `CODE_WRONG};
                default: syn_decode = {1'b0, `CODE_WRONG};
            endcase
        end
    endfunction

    // low-quality bits in a block, saturated at two
    function [1:0] low_count;
        input [25:0] q;
        integer i;
        reg [1:0] n;
        begin
            n = 2'd0;
            for (i = 0; i < 26; i = i + 1) begin
                if (!q[i] && n != 2'd2) begin
                    n = n + 2'd1;
                end
            end
            low_count = n;
        end
    endfunction

    // ***************************************
    // pin synchronisers
    // ***************************************
    reg [2:0] clk_s_q;
    reg [1:0] dat_s_q;
    reg [1:0] qal_s_q;
    wire bit_tick;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_s_q <= 3'h0;
            dat_s_q <= 2'h0;
            qal_s_q <= 2'h0;
        end else begin
            clk_s_q <= {clk_s_q[1:0], rds_bit_clock};
            dat_s_q <= {dat_s_q[0], rds_serial_bit};
            qal_s_q <= {qal_s_q[0], rds_quality};
        end
    end

    assign bit_tick = clk_s_q[1] & ~clk_s_q[2];

    // ***************************************
    // bus front end
    // ***************************************
    reg aw_have_q;
    reg [11:0] aw_addr_q;
    reg w_have_q;
    reg [7:0] w_data_q;
    reg w_lane_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [7:0] rdata_q;
    reg [1:0] rresp_q;
    reg [7:0] rd_val;
    wire do_wr;
    wire wr_en;
    wire [3:0] wr_idx;

    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready = ~w_have_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {24'h000000, rdata_q};
    assign s_axi_rresp = rresp_q;
    assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_en = do_wr & reg_hit(aw_addr_q) & w_lane_q;
    assign wr_idx = aw_addr_q[5:2];

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end else if (do_wr) begin
                w_have_q <= 1'b0;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= reg_hit(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (s_axi_arvalid && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= reg_hit(s_axi_araddr) ? rd_val : 8'h00;
                rresp_q <= reg_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ***************************************
    // unit state
    // ***************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam ST_ROT = 2'b10;
    localparam ST_END = 2'b11;

    reg [25:0] sr_q;
    reg [25:0] dr_q;
    reg [25:0] qr_q;
    reg [9:0] syn_q;
    reg paging_q;
    reg order_q;
    reg [2:0] code_q;
    reg [4:0] cnt_q;
    reg [4:0] latch_q;
    reg [1:0] blk_q;
    reg sync_q;
    reg running_q;
    reg ecm_q;
    reg vsf_q;
    reg vse_q;
    reg cnf_q;
    reg [1:0] sel_q;
    reg mqe_q;
    reg sqe_q;
    reg [1:0] st_q;
    reg [4:0] seq_q;
    reg hw_req_q;
    reg sw_req_q;
    reg hw_run_q;
    reg cni_pend_q;
    reg [35:0] r1;
    reg [35:0] r2;
    reg [1:0] nlow;
    wire zero_evt;
    wire [1:0] blk_next;
    wire grp_evt;
    wire [3:0] dec;
    wire rot_en;
    wire cal_wr;
    wire [25:0] q_new;

    assign zero_evt = (cnt_q <= 5'h01);
    assign blk_next = blk_q - 2'h1;
    assign grp_evt = zero_evt & (blk_next == 2'h0);
    assign dec = syn_decode(syn_q, paging_q);
    assign rot_en = ~ecm_q | ~hw_run_q;
    assign cal_wr = wr_en && wr_idx == 4'h7 && w_data_q[`BIT_CAL];
    assign q_new = {qr_q[24:0], qal_s_q[1]};

    always @* begin
        r1 = rot_step(sr_q, syn_q);
        r2 = rot_step(r1[35:10], r1[9:0]);
        nlow = low_count(q_new);
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sr_q <= 26'h0;
            dr_q <= 26'h0;
            qr_q <= 26'h0;
            syn_q <= 10'h000;
            paging_q <= 1'b0;
            order_q <= `RST_ORDER;
            code_q <= 3'h0;
            cnt_q <= `RST_BIT_CNT;
            latch_q <= `RST_BIT_CNT;
            blk_q <= `RST_BLK_CNT;
            sync_q <= 1'b0;
            running_q <= 1'b0;
            ecm_q <= 1'b0;
            vsf_q <= 1'b0;
            vse_q <= 1'b0;
            cnf_q <= 1'b0;
            sel_q <= 2'h0;
            mqe_q <= 1'b0;
            sqe_q <= 1'b0;
            st_q <= ST_IDLE;
            seq_q <= 5'h0;
            hw_req_q <= 1'b0;
            sw_req_q <= 1'b0;
            hw_run_q <= 1'b0;
            cni_pend_q <= 1'b0;
        end else begin
            // bit clock edge: shadow shift, counters, one-period flags
            if (bit_tick) begin
                dr_q <= {dr_q[24:0], dat_s_q[1]};
                qr_q <= q_new;
                cnt_q <= zero_evt ? latch_q : cnt_q - 5'h01;
                if (zero_evt) begin
                    blk_q <= blk_next;
                end
                sync_q <= zero_evt;
                sqe_q <= zero_evt && nlow == 2'd1;
                mqe_q <= zero_evt && nlow == 2'd2;
                hw_req_q <= 1'b1;
                case (sel_q)
                    2'b01: cni_pend_q <= 1'b1;
                    2'b10: cni_pend_q <= zero_evt;
                    2'b11: cni_pend_q <= grp_evt;
                    default: cni_pend_q <= 1'b0;
                endcase
            end
            if (cal_wr) begin
                sw_req_q <= 1'b1;
                running_q <= 1'b1;
            end
            // calculation sequencer
            case (st_q)
                ST_IDLE: begin
                    if (hw_req_q || sw_req_q) begin
                        hw_run_q <= hw_req_q;
                        if (hw_req_q) begin
                            hw_req_q <= bit_tick;
                        end else begin
                            sw_req_q <= cal_wr;
                        end
                        st_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (hw_run_q && !ecm_q) begin
                        sr_q <= {sr_q[24:0], dr_q[0]};
                    end
                    if (rot_en) begin
                        syn_q <= 10'h000;
                    end
                    seq_q <= 5'h01;
                    st_q <= ST_ROT;
                end
                ST_ROT: begin
                    if (rot_en) begin
                        sr_q <= r2[35:10];
                        syn_q <= r2[9:0];
                    end
                    seq_q <= seq_q + 5'h02;
                    if (seq_q == `SEQ_LAST_ROT) begin
                        st_q <= ST_END;
                    end
                end
                ST_END: begin
                    code_q <= dec[2:0];
                    order_q <= (blk_q == dec[1:0]);
                    vsf_q <= dec[3];
                    if (cni_pend_q) begin
                        cnf_q <= 1'b1;
                    end
                    if (!bit_tick) begin
                        cni_pend_q <= 1'b0;
                    end
                    // a hardware pass must not end a software calculation still queued
                    if (!hw_run_q) begin
                        running_q <= cal_wr | sw_req_q;
                    end
                    seq_q <= `SEQ_END;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
            // software writes; hardware set of a flag wins over a clear
            if (wr_en) begin
                case (wr_idx)
                    4'h0: sr_q[1:0] <= w_data_q[7:6];
                    4'h1: sr_q[9:2] <= w_data_q;
                    4'h2: sr_q[17:10] <= w_data_q;
                    4'h3: sr_q[25:18] <= w_data_q;
                    4'h4: paging_q <= w_data_q[`BIT_PAGING];
                    4'h6: begin
                        blk_q <= w_data_q[7:6];
                        cnt_q <= w_data_q[4:0];
                        latch_q <= w_data_q[4:0];
                    end
                    4'h7: begin
                        ecm_q <= w_data_q[`BIT_ECM];
                        vse_q <= w_data_q[`BIT_VSE];
                        sel_q <= w_data_q[1:0];
                        if (!w_data_q[`BIT_VSF] && st_q != ST_END) begin
                            vsf_q <= 1'b0;
                        end
                        if (!w_data_q[`BIT_CNF] && !(st_q == ST_END && cni_pend_q)) begin
                            cnf_q <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ***************************************
    // read data
    // ***************************************
    always @* begin
        case (s_axi_araddr[5:2])
            4'h0: rd_val = {sr_q[1:0], 6'h00};
            4'h1: rd_val = sr_q[9:2];
            4'h2: rd_val = sr_q[17:10];
            4'h3: rd_val = sr_q[25:18];
            4'h4: rd_val = {syn_q[1:0], 1'b0, paging_q, order_q, code_q};
            4'h5: rd_val = syn_q[9:2];
            4'h6: rd_val = {blk_q, sync_q, cnt_q};
            4'h7: rd_val = {1'b0, running_q, ecm_q, vsf_q, vse_q, cnf_q, sel_q};
            4'h8: rd_val = {dr_q[1:0], 1'b0, mqe_q, sqe_q, qal_s_q[1], clk_s_q[1], dat_s_q[1]};
            4'h9: rd_val = dr_q[9:2];
            4'ha: rd_val = dr_q[17:10];
            4'hb: rd_val = dr_q[25:18];
            4'hc: rd_val = {qr_q[1:0], 6'h00};
            4'hd: rd_val = qr_q[9:2];
            4'he: rd_val = qr_q[17:10];
            default: rd_val = qr_q[25:18];
        endcase
    end

    assign sync_unit_irq_line = (vsf_q & vse_q) | cnf_q;

endmodule

// File: bench/rds_sync_checker_properties.sv
// checker for the sync unit register bus and the live pin readback
// assumes: bound to rds_group_block_sync, one clock domain, data in bits 7:0
`timescale 1ns/1ps

module rds_sync_checker (
    input wire sys_clk,
    input wire arst_n,
    input wire rds_bit_clock,
    input wire rds_serial_bit,
    input wire rds_quality,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ****************
    // sequences
    // ****************
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_at(a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    sequence pins_still;
        ($stable(rds_bit_clock) && $stable(rds_serial_bit) && $stable(rds_quality))[*4];
    endsequence
    // ****************
    // assertions
    // ****************
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after both taken");
    write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr < 12'h180 ||
        s_axi_araddr > 12'h1bc) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    checkword_pad_a: assert property (rd_at(12'h180) |=> s_axi_rdata[5:0] == 6'h0)
        else $error("checkword low byte padding not zero");
    start_reads_zero_a: assert property (rd_at(12'h19c) |=> !s_axi_rdata[7])
        else $error("start bit read as one");
    quality_pad_a: assert property (rd_at(12'h1b0) |=> s_axi_rdata[5:0] == 6'h0)
        else $error("quality low byte padding not zero");
    live_levels_a: assert property (pins_still ##0 rd_at(12'h1a0) |=>
        s_axi_rdata[2:0] == {$past(rds_quality), $past(rds_bit_clock), $past(rds_serial_bit)})
        else $error("live pin levels wrong");
endmodule

bind rds_group_block_sync rds_sync_checker u_chk (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .rds_bit_clock(rds_bit_clock),
    .rds_serial_bit(rds_serial_bit),
    .rds_quality(rds_quality),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// File: bench/rds_demod_model.sv
// demodulator model: bit clock, data and quality pins, 125 ns bit period
// assumes: caller sends bits one by one; clock stands low between frames
`timescale 1ns/1ps

module rds_demod_model (
    output logic rds_bit_clock,
    output logic rds_serial_bit,
    output logic rds_quality
);
    initial begin
        rds_bit_clock = 1'b0;
        rds_serial_bit = 1'b0;
        rds_quality = 1'b1;
    end
    // pins move off the sys_clk rising edges; data held over the whole high phase
    task automatic send_bit(input logic d, input logic q);
        #1 rds_serial_bit = d;
        rds_quality = q;
        #61.5 rds_bit_clock = 1'b1;
        #61 rds_bit_clock = 1'b0;
        #1.5;
    endtask
    // released lines no longer show the last bit
    task automatic idle();
        #1 rds_serial_bit = ~rds_serial_bit;
        rds_quality = ~rds_quality;
    endtask
endmodule

// File: bench/rds_group_block_sync_test.sv
// self-checking bench for the group/block sync unit
// assumes: demodulator model drives the link pins; registers reached over AXI4-Lite
`timescale 1ns/1ps
`include "rds_sync_regs.vh"

module rds_group_block_sync_test;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_unit_irq_line;
    wire rds_bit_clock, rds_serial_bit, rds_quality;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    exp_t rq[$];
    exp_t ex;
    logic [1:0] wq[$];
    int err_count = 0, checks = 0, cyc = 0;
    logic [25:0] d1, q1;
    logic [9:0] sy;
    logic [2:0] cd;

    always #2.5 sys_clk = ~sys_clk;

    rds_demod_model u_demod (
        .rds_bit_clock(rds_bit_clock),
        .rds_serial_bit(rds_serial_bit),
        .rds_quality(rds_quality)
    );

    rds_group_block_sync u_dut (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .rds_bit_clock(rds_bit_clock),
        .rds_serial_bit(rds_serial_bit),
        .rds_quality(rds_quality),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .sync_unit_irq_line(sync_unit_irq_line)
    );

    // ****************
    // reference and bus tasks
    // ****************
    function automatic logic [9:0] syn_of(input logic [25:0] b);
        logic [9:0] s;
        s = 10'h0;
        for (int i = 25; i >= 0; i--) s = {s[8:0], 1'b0} ^ ((s[9] ^ b[i]) ? `SYN_POLY : 10'h0);
        return s;
    endfunction

    function automatic logic [2:0] code_of(input logic [9:0] s, input logic pg);
        case (s)
            `SYN_A: return `CODE_A;
            `SYN_B: return `CODE_B;
            `SYN_C: return `CODE_C;
            `SYN_CP: return `CODE_CP;
            `SYN_D: return `CODE_D;
            `SYN_E: return pg ? `CODE_E : `CODE_WRONG;
            default: return `CODE_WRONG;
        endcase
    endfunction

    function automatic logic [1:0] resp_of(input logic [7:0] i);
        return (i >= `IDX_FIRST && i <= `IDX_LAST) ? `RESP_OKAY : `RESP_SLVERR;
    endfunction

    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        @(posedge sys_clk);
        wq.push_back(resp_of(i));
        s_axi_awaddr <= {2'b0, i, 2'b0};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
        @(posedge sys_clk);
        rq.push_back({24'h0, e, 24'hffffff, m, resp_of(i)});
        s_axi_araddr <= {2'b0, i, 2'b0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic bytes(input logic [7:0] b, input logic [25:0] x, input logic [7:0] m0);
        rd(b, {x[1:0], 6'h0}, m0);
        rd(b + 8'h1, x[9:2], 8'hff);
        rd(b + 8'h2, x[17:10], 8'hff);
        rd(b + 8'h3, x[25:18], 8'hff);
    endtask

    task automatic frame(input int n, input logic [25:0] d, input logic [25:0] q);
        for (int i = n - 1; i >= 0; i--) u_demod.send_bit(d[i], q[i]);
        u_demod.idle();
        repeat (30) @(posedge sys_clk);
    endtask

    task automatic irq_is(input logic e);
        @(negedge sys_clk);
        checks++;
        if (sync_unit_irq_line !== e) begin
            err_count++;
            $display("unexpected %0t interrupt line %b", $time, sync_unit_irq_line);
        end
    endtask

    task automatic results();
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ****************
    // response monitor and timeout
    // ****************
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            ex = rq.pop_front();
            checks++;
            if (((s_axi_rdata ^ ex.d) & ex.m) !== 32'h0 || s_axi_rresp !== ex.r) begin
                err_count++;
                $display("unexpected %0t read %h resp %h", $time, s_axi_rdata, s_axi_rresp);
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            checks++;
            if (s_axi_bresp !== wq.pop_front()) begin
                err_count++;
                $display("unexpected %0t write resp %h", $time, s_axi_bresp);
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            results();
        end
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        void'($urandom(8));
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++) rd(8'h60 + i[7:0], i == 4 ? 8'h08 : i == 6 ? 8'hdf : 8'h00, i == 8 ? 8'hf8 : 8'hff);
        rd(8'h70, 8'h00, 8'hff);
        wr(8'h70, 8'hff);
        wr(`IDX_BIT_BLOCK_COUNTERS, 8'hda);
        rd(`IDX_BIT_BLOCK_COUNTERS, 8'hda, 8'hff);
        wr(`IDX_INTERRUPT_CONTROL, 8'h02);
        d1 = 26'($urandom);
        q1 = ~(26'h1 << ($urandom % 26));
        frame(26, d1, q1);
        sy = syn_of(d1);
        cd = code_of(sy, 1'b0);
        bytes(8'h60, d1, 8'hff);
        rd(8'h64, {sy[1:0], 2'b00, cd[1:0] == 2'b10, cd}, 8'hff);
        rd(8'h65, sy[9:2], 8'hff);
        rd(8'h66, 8'hba, 8'hff);
        rd(8'h67, {3'b000, cd != `CODE_WRONG, 4'b0110}, 8'hff);
        bytes(8'h68, d1, 8'hc0);
        rd(8'h68, {5'b00001, ~q1[0], 1'b0, ~d1[0]}, 8'h3f);
        bytes(8'h6c, q1, 8'hff);
        irq_is(1'b1);
        wr(8'h67, 8'h02);
        rd(8'h67, 8'h02, 8'hff);
        irq_is(1'b0);
        wr(8'h64, 8'h10);
        wr(8'h67, 8'h08);
        q1 = ~26'h100008;
        frame(26, 26'h0, q1);
        rd(8'h64, 8'h1d, 8'hff);
        rd(8'h66, 8'h7a, 8'hff);
        rd(8'h67, 8'h18, 8'hff);
        rd(8'h68, 8'h11, 8'hff);
        irq_is(1'b1);
        wr(8'h67, 8'h10);
        irq_is(1'b0);
        wr(8'h64, 8'h00);
        wr(8'h67, 8'h90);
        rd(8'h67, 8'h40, 8'hc0);
        repeat (40) @(posedge sys_clk);
        rd(8'h67, 8'h00, 8'hff);
        rd(8'h64, 8'h07, 8'hff);
        wr(8'h67, 8'h20);
        d1 = {22'h0, 4'($urandom)};
        frame(4, d1, '1);
        bytes(8'h60, 26'h0, 8'hff);
        bytes(8'h68, d1, 8'hc0);
        wr(8'h67, 8'h00);
        for (int i = 0; i < 4; i++) wr(8'h60 + i[7:0], i == 0 ? {d1[1:0], 6'h0} : d1[8 * i - 6 +: 8]);
        bytes(8'h60, d1, 8'hff);
        for (int m = 0; m < 4; m++) begin
            wr(8'h66, m == 3 ? 8'h41 : 8'h81);
            wr(8'h67, m[7:0]);
            frame(1, 26'($urandom), '1);
            rd(8'h66, m == 3 ? 8'h21 : 8'h61, 8'hff);
            rd(8'h67, {5'h0, m != 0, m[1:0]}, 8'h2f);
        end
        results();
    end
endmodule
